// *** tb/switch_decoder_monitor.sv ***
// port assertions for the configuration switch decoder
`timescale 1ns/100ps
module switch_decoder_monitor (
   input wire logic                          clock,
   input wire logic                          resetn,
   input wire logic                          wb_cyc_i,
   input wire logic                          wb_stb_i,
   input wire logic                          wb_ack_o,
   input wire logic                          unit_is_master,
   input wire logic                          transmit_timing,
   input wire logic                          transmit_serial_in,
   input wire switch_decoder_pkg::controls_t controls,
   input wire logic                          tx_clock_enable,
   input wire logic                          tx_bit,
   input wire logic                          tx_bit_valid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_enable_mode: assert property (tx_clock_enable == (controls.clock_mode != switch_decoder_pkg::clk_reserved))
      else $error("clock enable disagrees with clock mode");
   a_master_modes: assert property ((controls.clock_mode == switch_decoder_pkg::clk_internal ||
      controls.clock_mode == switch_decoder_pkg::clk_external) |-> $past(unit_is_master, 3))
      else $error("master clock mode on slave unit");
   a_recover_slave: assert property (controls.clock_mode == switch_decoder_pkg::clk_recover
      |-> !$past(unit_is_master, 3))
      else $error("recover clock mode on master unit");
   a_fall_sample: assert property (tx_bit_valid && !controls.sample_rising
      |-> !$past(transmit_timing, 3) && $past(transmit_timing, 6))
      else $error("sample not on falling timing edge");
   a_rise_sample: assert property (tx_bit_valid && controls.sample_rising
      |-> $past(transmit_timing, 3) && !$past(transmit_timing, 6))
      else $error("sample not on rising timing edge");
   a_sample_data: assert property (tx_bit_valid |-> tx_bit == $past(transmit_serial_in, 4))
      else $error("sampled bit differs from line");
   a_line_rate: assert property (controls.rate_valid |-> controls.line_kbps >= controls.terminal_kbps &&
      controls.line_kbps % 11'h090 == 11'h000 && controls.terminal_kbps % 11'h040 == 11'h000)
      else $error("line rate cannot carry terminal rate");
endmodule // switch_decoder_monitor

bind switch_decoder switch_decoder_monitor mon (.clock, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .unit_is_master, .transmit_timing, .transmit_serial_in, .controls, .tx_clock_enable, .tx_bit, .tx_bit_valid);

// *** tb/switch_decoder_tb.sv ***
// self-checking bench for the configuration switch decoder
`timescale 1ns/100ps
module switch_decoder_tb;
   logic        clock = 1'b0, resetn = 1'b0, master = 1'b1, loc_req = 1'b0, rem_req = 1'b0;
   logic [7:0]  bank_a = 8'h00, bank_b = 8'h00;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, tx_en, tx_bit, tx_valid, lamp, timing, sdata;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rd, rdat;
   logic        run = 1'b0, sampling_on = 1'b0, exp_rising = 1'b0;
   logic [5:0]  code;
   switch_decoder_pkg::controls_t ctl;
   logic        exp_q[$];
   int          err_count = 0, checks_done = 0, cycles = 0;

   always #5 clock = ~clock;

   switch_decoder dut (.clock(clock), .resetn(resetn), .switch_bank_a_on(bank_a), .switch_bank_b_on(bank_b),
      .unit_is_master(master), .local_loop_request(loc_req), .remote_loop_request(rem_req),
      .transmit_timing(timing), .transmit_serial_in(sdata), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .irq(irq),
      .controls(ctl), .tx_clock_enable(tx_en), .tx_bit(tx_bit), .tx_bit_valid(tx_valid), .fault_lamp(lamp));

   terminal_model term (.run(run), .launch_on_rise(~exp_rising), .transmit_timing(timing),
      .transmit_serial_in(sdata));

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (n >= 16) chk(32'h0, 32'h1);
      rdat = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wait_mode(input switch_decoder_pkg::clock_mode_t m);
      int n;
      n = 0;
      while (ctl.clock_mode !== m && n < 20000) begin
         @(posedge clock);
         n++;
      end
      chk(32'(ctl.clock_mode), 32'(m));
      repeat (4) @(posedge clock);
   endtask

   function automatic logic [31:0] status_exp(logic [1:0] lp, logic [5:0] c, logic [2:0] f);
      logic [10:0] k, line;
      k = 11'(c - 6'h02) * 11'h040;
      line = 11'h090;
      while (line < k) line += 11'h090;
      return {8'h00, f, line, c, lp, 2'b00};
   endfunction

   task automatic stream(input logic rising);
      exp_rising = rising;
      sampling_on = 1'b1;
      run = 1'b1;
      repeat (400) @(posedge clock);
      run = 1'b0;
      repeat (30) @(posedge clock);
      sampling_on = 1'b0;
      chk(32'(exp_q.size()), 32'h0);
   endtask

   always @(timing) if (sampling_on && timing == exp_rising) exp_q.push_back(sdata);

   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         conclude();
      end
      if (sampling_on && tx_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(tx_bit), 32'(exp_q.pop_front()));
      end
   end

   initial begin
      void'($urandom(50554));
      code = 6'(3 + $urandom % 18);
      bank_a <= 8'he0;
      bank_b <= {2'b11, ~code};
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      wb(1'b0, 4'h0, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, 4'hc, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b1, 4'h6, 32'hffff_ffff);
      wb(1'b0, 4'h6, 32'h0);
      chk(rdat, 32'h0);
      wait_mode(switch_decoder_pkg::clk_internal);
      wb(1'b0, 4'h4, 32'h0);
      chk(rdat, status_exp(2'b00, code, 3'b001));
      chk(32'(tx_en), 32'h1);
      chk(32'(ctl.terminal_kbps), 32'(code - 6'h02) * 32'h40);
      wb(1'b1, 4'h8, 32'hf);
      wb(1'b0, 4'h8, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b1, 4'hc, 32'h2);
      loc_req <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_local));
      chk(32'(irq), 32'h1);
      wb(1'b0, 4'h8, 32'h0);
      chk(rdat, 32'h2);
      wb(1'b1, 4'h8, 32'h2);
      chk(32'(irq), 32'h0);
      loc_req <= 1'b0;
      rem_req <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_remote));
      chk(32'(irq), 32'h1);
      wb(1'b1, 4'hc, 32'h0);
      chk(32'(irq), 32'h0);
      rem_req <= 1'b0;
      wb(1'b1, 4'h8, 32'hf);
      stream(1'b0);
      bank_a <= 8'h40;
      bank_b <= {2'b00, ~6'h15};
      wait_mode(switch_decoder_pkg::clk_external);
      chk(32'({ctl.restore_defaults, ctl.sample_rising, ctl.rate_valid}), 32'h6);
      loc_req <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_none));
      wb(1'b1, 4'h0, 32'h1);
      repeat (6) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_local));
      wb(1'b1, 4'h0, 32'h2);
      repeat (6) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_remote));
      wb(1'b1, 4'h0, 32'h0);
      repeat (6) @(posedge clock);
      chk(32'(ctl.loop_state), 32'(switch_decoder_pkg::loop_none));
      loc_req <= 1'b0;
      stream(1'b1);
      master <= 1'b0;
      repeat (4) @(posedge clock);
      chk(32'(ctl.clock_mode), 32'(switch_decoder_pkg::clk_reserved));
      chk(32'(tx_en), 32'h0);
      // power-up again as a slave unit with an unsupported rate code
      bank_a <= 8'h20;
      bank_b <= 8'hff;
      resetn <= 1'b0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      wait_mode(switch_decoder_pkg::clk_recover);
      wb(1'b0, 4'h8, 32'h0);
      chk(rdat, 32'h8);
      chk(32'({lamp, tx_en, ctl.rate_valid}), 32'h2);
      conclude();
   end
endmodule // switch_decoder_tb

// *** tb/terminal_model.sv ***
// terminal side model: transmit timing clock and transmit data
`timescale 1ns/100ps
module terminal_model (
   input  wire logic run,
   input  wire logic launch_on_rise,
   output logic      transmit_timing,
   output logic      transmit_serial_in
);
   logic [15:0] pattern_reg = 16'hace1;

   // phase offset keeps timing edges away from system clock edges
   initial begin
      transmit_timing = 1'b0;
      transmit_serial_in = 1'b0;
      #3;
      forever #80 if (run || transmit_timing) transmit_timing = ~transmit_timing;
   end

   // data moves on the edge opposite the sampling edge
   always @(transmit_timing) if (transmit_timing == launch_on_rise) begin
      pattern_reg = {pattern_reg[14:0], pattern_reg[15] ^ pattern_reg[13] ^ pattern_reg[12] ^ pattern_reg[10]};
      transmit_serial_in = pattern_reg[0];
   end
endmodule // terminal_model

// *** verilog/switch_decoder.sv ***
// configuration switch decoder with wishbone registers and transmit data sampler
`timescale 1ns/100ps
`include "switch_decoder_params.svh"

// What this block does
// - master unit, bank a 6 and 7 On: internal transmit clock.
// - slave unit, 6 On 7 Off: transmit clock from recovered line clock.
// - four clock modes counting reserved; master, 6 Off 7 On: clock from terminal.
// - bank a 8 On: terminal local and remote requests enter loopback.
// - bank a 8 Off: terminal loop requests ignored, test state cleared to none.
// - front-panel loop requests always accepted.
// - bank b 1..6, Off is one, LSB first; rate 64 kbps times code minus 2.
// - pick lowest line rate carrying the terminal rate, with headroom.
// - unsupported rate code at power-up blinks the fault lamp every 200 ms.
// - bank b 7 Off requests restore of factory defaults.
// - bank b 8 On: sample transmit data on falling timing edge.
// - bank b 8 Off: sample transmit data on rising timing edge.
module switch_decoder (
   input  wire logic                          clock,
   input  wire logic                          resetn,
   input  wire logic [7:0]                    switch_bank_a_on,
   input  wire logic [7:0]                    switch_bank_b_on,
   input  wire logic                          unit_is_master,
   input  wire logic                          local_loop_request,
   input  wire logic                          remote_loop_request,
   input  wire logic                          transmit_timing,
   input  wire logic                          transmit_serial_in,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [3:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   output logic                               irq,
   output switch_decoder_pkg::controls_t      controls,
   output logic                               tx_clock_enable,
   output logic                               tx_bit,
   output logic                               tx_bit_valid,
   output logic                               fault_lamp
);

   // ==========================================================
   // synchronisers
   localparam int NSYNC = 21;
   logic [NSYNC-1:0] sync1_reg, sync2_reg;
   logic [NSYNC-1:0] raw_in;
   assign raw_in = {unit_is_master, transmit_serial_in, transmit_timing, remote_loop_request, local_loop_request,
                    switch_bank_b_on, switch_bank_a_on};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // ==========================================================
   // switch debounce, one counter per switch
   localparam int DBW = $clog2(`DEBOUNCE_CYCLES + 1);
   localparam logic [DBW-1:0] DB_LAST = DBW'(`DEBOUNCE_CYCLES - 1);
   logic [15:0]    sw_reg, sw_next;
   logic [15:0]    sw_valid_reg, sw_valid_next;
   logic [DBW-1:0] db_cnt_reg [16];
   logic [DBW-1:0] db_cnt_next [16];

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_db
         always_comb begin
            sw_next[gi]       = sw_reg[gi];
            sw_valid_next[gi] = sw_valid_reg[gi];
            db_cnt_next[gi]   = '0;
            if (sync2_reg[gi] != sw_reg[gi] || !sw_valid_reg[gi]) begin
               if (db_cnt_reg[gi] == DB_LAST) begin
                  sw_next[gi]       = sync2_reg[gi];
                  sw_valid_next[gi] = 1'b1;
               end else begin
                  db_cnt_next[gi] = db_cnt_reg[gi] + DBW'(1);
               end
            end
         end
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               db_cnt_reg[gi]   <= '0;
               sw_reg[gi]       <= 1'b0;
               sw_valid_reg[gi] <= 1'b0;
            end else begin
               db_cnt_reg[gi]   <= db_cnt_next[gi];
               sw_reg[gi]       <= sw_next[gi];
               sw_valid_reg[gi] <= sw_valid_next[gi];
            end
         end
      end
   endgenerate

   logic switches_ready;
   assign switches_ready = &sw_valid_reg;

   // ==========================================================
   // decode functions
   function automatic switch_decoder_pkg::clock_mode_t decode_clock(input logic s6, input logic s7,
                                                                     input logic master);
      if (s6 && s7 && master)
         return switch_decoder_pkg::clk_internal;
      else if (!s6 && s7 && master)
         return switch_decoder_pkg::clk_external;
      else if (s6 && !s7 && !master)
         return switch_decoder_pkg::clk_recover;
      else
         return switch_decoder_pkg::clk_reserved;
   endfunction

   function automatic logic [5:0] rate_code(input logic [5:0] on_bits);
      return ~on_bits;
   endfunction

   function automatic logic code_ok(input logic [5:0] code);
      return (code >= `RATE_CODE_MIN) && (code <= `RATE_CODE_MAX);
   endfunction

   // ==========================================================
   // registers
   logic [31:0]             ctrl_reg, ctrl_next;
   logic [`IRQ_WIDTH-1:0]   irq_stat_reg, irq_stat_next;
   logic [`IRQ_WIDTH-1:0]   irq_mask_reg, irq_mask_next;
   logic                    ack_reg, ack_next;
   logic [31:0]             rdata_reg, rdata_next;
   switch_decoder_pkg::loop_state_t loop_reg, loop_next;
   logic [15:0]             sw_seen_reg;
   logic                    ready_seen_reg;
   logic                    bad_latched_reg, bad_latched_next;

   logic [5:0]  code;
   logic        valid;
   logic [10:0] term_kbps, line_kbps;
   logic [3:0]  headroom;

   always_comb begin
      logic [3:0] k;
      k         = 4'h0;
      code      = rate_code(sw_reg[13:8]);
      valid     = code_ok(code);
      term_kbps = valid ? 11'(code - `RATE_CODE_OFFSET) * `RATE_STEP_KBPS : 11'h000;
      headroom  = ctrl_reg[`CTRL_HEADROOM_LSB +: 4];
      line_kbps = 11'h000;
      // line rates are multiples of 144 kbps; pick the lowest that fits
      for (int i = 8; i >= 1; i = i - 1) begin
         if (11'(i) * `LINE_STEP_KBPS >= term_kbps)
            k = 4'(i);
      end
      if (valid) begin
         if (k == 4'h0)
            k = `LINE_STEPS_MAX;
         if (5'(k) + 5'(headroom) > 5'(`LINE_STEPS_MAX))
            k = `LINE_STEPS_MAX;
         else
            k = k + headroom;
         line_kbps = 11'(k) * `LINE_STEP_KBPS;
      end
   end

   // loopback state
   logic panel_local, panel_remote, term_en;
   assign panel_local  = ctrl_reg[`CTRL_PANEL_LOCAL];
   assign panel_remote = ctrl_reg[`CTRL_PANEL_REMOTE];
   assign term_en      = sw_reg[7];

   always_comb begin
      loop_next = loop_reg;
      if (panel_local)
         loop_next = switch_decoder_pkg::loop_local;
      else if (panel_remote)
         loop_next = switch_decoder_pkg::loop_remote;
      else if (term_en) begin
         if (sync2_reg[16])
            loop_next = switch_decoder_pkg::loop_local;
         else if (sync2_reg[17])
            loop_next = switch_decoder_pkg::loop_remote;
         else
            loop_next = switch_decoder_pkg::loop_none;
      end else begin
         // terminal requests dropped; loop state returns to none
         loop_next = switch_decoder_pkg::loop_none;
      end
   end

   // ==========================================================
   // wishbone slave and interrupts
   logic       req, wr;
   logic [`IRQ_WIDTH-1:0] events;
   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

   assign events[`IRQ_SWITCH_CHANGE] = switches_ready && ready_seen_reg && (sw_reg != sw_seen_reg);
   assign events[`IRQ_LOOP_CHANGE]   = switches_ready && (loop_next != loop_reg);
   assign events[`IRQ_DEFAULTS_REQ]  = switches_ready && !sw_reg[14] &&
                                       (!ready_seen_reg || sw_seen_reg[14]);
   assign events[`IRQ_BAD_RATE]      = switches_ready && !ready_seen_reg && !valid;

   always_comb begin
      ctrl_next     = ctrl_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      ack_next      = req;
      rdata_next    = rdata_reg;
      if (wr && wb_adr_i == `ADDR_CONTROL) begin
         for (int b = 0; b < 4; b = b + 1) begin
            if (wb_sel_i[b])
               ctrl_next[8*b +: 8] = wb_dat_i[8*b +: 8];
         end
      end
      if (wr && wb_adr_i == `ADDR_IRQ_MASK && wb_sel_i[0])
         irq_mask_next = wb_dat_i[`IRQ_WIDTH-1:0];
      if (wr && wb_adr_i == `ADDR_IRQ_STATUS && wb_sel_i[0])
         irq_stat_next = irq_stat_reg & ~wb_dat_i[`IRQ_WIDTH-1:0];
      irq_stat_next = irq_stat_next | events; // set wins over clear
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            `ADDR_CONTROL:    rdata_next = ctrl_reg;
            `ADDR_STATUS:     rdata_next = {8'h00, controls.restore_defaults, controls.sample_rising,
                                            valid, line_kbps, code, loop_reg, controls.clock_mode};
            `ADDR_IRQ_STATUS: rdata_next = {28'h0000000, irq_stat_reg};
            `ADDR_IRQ_MASK:   rdata_next = {28'h0000000, irq_mask_reg};
            default:          rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg       <= `CTRL_RESET_VALUE;
         irq_stat_reg   <= '0;
         irq_mask_reg   <= '0;
         ack_reg        <= 1'b0;
         rdata_reg      <= 32'h0000_0000;
         loop_reg       <= switch_decoder_pkg::loop_none;
         sw_seen_reg    <= 16'h0000;
         ready_seen_reg <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         irq_stat_reg   <= irq_stat_next;
         irq_mask_reg   <= irq_mask_next;
         ack_reg        <= ack_next;
         rdata_reg      <= rdata_next;
         loop_reg       <= switches_ready ? loop_next : loop_reg;
         sw_seen_reg    <= sw_reg;
         ready_seen_reg <= switches_ready;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
   assign irq      = |(irq_stat_reg & irq_mask_reg);

   // ==========================================================
   // decoded controls
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         controls <= '{clock_mode: switch_decoder_pkg::clk_reserved, loop_state: switch_decoder_pkg::loop_none,
                       terminal_kbps: 11'h000, line_kbps: 11'h000, rate_valid: 1'b0,
                       restore_defaults: 1'b0, sample_rising: 1'b0};
      end else if (switches_ready) begin
         controls.clock_mode       <= decode_clock(sw_reg[5], sw_reg[6], sync2_reg[20]);
         controls.loop_state       <= loop_reg;
         controls.terminal_kbps    <= term_kbps;
         controls.line_kbps        <= line_kbps;
         controls.rate_valid       <= valid;
         controls.restore_defaults <= !sw_reg[14];
         controls.sample_rising    <= !sw_reg[15];
      end
   end

   assign tx_clock_enable = (controls.clock_mode != switch_decoder_pkg::clk_reserved);

   // ==========================================================
   // transmit data sampler on the selected timing edge
   logic timing_prev_reg;
   logic tx_bit_reg, tx_bit_next, tx_valid_reg, tx_valid_next;
   always_comb begin
      logic rise, fall;
      rise          = sync2_reg[18] && !timing_prev_reg;
      fall          = !sync2_reg[18] && timing_prev_reg;
      tx_bit_next   = tx_bit_reg;
      tx_valid_next = 1'b0;
      if (controls.sample_rising ? rise : fall) begin
         tx_bit_next   = sync2_reg[19];
         tx_valid_next = switches_ready;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timing_prev_reg <= 1'b0;
         tx_bit_reg      <= 1'b0;
         tx_valid_reg    <= 1'b0;
      end else begin
         timing_prev_reg <= sync2_reg[18];
         tx_bit_reg      <= tx_bit_next;
         tx_valid_reg    <= tx_valid_next;
      end
   end
   assign tx_bit       = tx_bit_reg;
   assign tx_bit_valid = tx_valid_reg;

   // ==========================================================
   // fault lamp blink for unsupported rate at power-up
   localparam int BLW = $clog2(`BLINK_CYCLES + 1);
   localparam logic [BLW-1:0] BLINK_LAST = BLW'(`BLINK_CYCLES / 2 - 1);
   logic [BLW-1:0] blink_cnt_reg, blink_cnt_next;
   logic           lamp_reg, lamp_next;
   always_comb begin
      bad_latched_next = bad_latched_reg | events[`IRQ_BAD_RATE];
      blink_cnt_next   = '0;
      lamp_next        = 1'b0;
      if (bad_latched_reg) begin
         blink_cnt_next = (blink_cnt_reg == BLINK_LAST) ? '0 : blink_cnt_reg + BLW'(1);
         lamp_next      = (blink_cnt_reg == BLINK_LAST) ? ~lamp_reg : lamp_reg;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bad_latched_reg <= 1'b0;
         blink_cnt_reg   <= '0;
         lamp_reg        <= 1'b0;
      end else begin
         bad_latched_reg <= bad_latched_next;
         blink_cnt_reg   <= blink_cnt_next;
         lamp_reg        <= lamp_next;
      end
   end
   assign fault_lamp = lamp_reg;

endmodule // switch_decoder

// *** verilog/switch_decoder_params.svh ***
// constants for the configuration switch decoder
`ifndef SWITCH_DECODER_PARAMS_SVH
`define SWITCH_DECODER_PARAMS_SVH

`define CLK_PERIOD_NS      10
`define DEBOUNCE_TIME_US   100
`define DEBOUNCE_CYCLES    ((`DEBOUNCE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BLINK_TIME_MS      200
`define BLINK_CYCLES       ((`BLINK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define RATE_CODE_MIN      6'h03
`define RATE_CODE_MAX      6'h14
`define RATE_CODE_OFFSET   6'h02
`define RATE_STEP_KBPS     11'h040
`define LINE_STEP_KBPS     11'h090
`define LINE_STEPS_MAX     4'h8

// wishbone register byte addresses
`define ADDR_CONTROL       4'h0
`define ADDR_STATUS        4'h4
`define ADDR_IRQ_STATUS    4'h8
`define ADDR_IRQ_MASK      4'hc

// control fields
`define CTRL_PANEL_LOCAL   0
`define CTRL_PANEL_REMOTE  1
`define CTRL_HEADROOM_LSB  4
`define CTRL_RESET_VALUE   32'h0000_0000

// interrupt status fields
`define IRQ_SWITCH_CHANGE  0
`define IRQ_LOOP_CHANGE    1
`define IRQ_DEFAULTS_REQ   2
`define IRQ_BAD_RATE       3
`define IRQ_WIDTH          4

`endif

// *** verilog/switch_decoder_pkg.sv ***
// types for the configuration switch decoder
package switch_decoder_pkg;

   typedef enum logic [1:0] {
      clk_internal = 2'b00,
      clk_external = 2'b01,
      clk_recover  = 2'b10,
      clk_reserved = 2'b11
   } clock_mode_t;

   typedef enum logic [1:0] {
      loop_none   = 2'b00,
      loop_local  = 2'b01,
      loop_remote = 2'b10
   } loop_state_t;

   typedef struct packed {
      clock_mode_t clock_mode;
      loop_state_t loop_state;
      logic [10:0] terminal_kbps;
      logic [10:0] line_kbps;
      logic        rate_valid;
      logic        restore_defaults;
      logic        sample_rising;
   } controls_t;

endpackage
